// ==== pkg/dadc_pkg.sv ====
package dadc_pkg;

  // frame layout on the serial result line
  localparam int unsigned NULL_BITS  = 4;
  localparam int unsigned DATA_BITS  = 12;
  localparam int unsigned FRAME_BITS = NULL_BITS + DATA_BITS;
  localparam int unsigned CNT_W      = 5;

  // sample buffer between front end and converter core
  localparam int unsigned FIFO_DEPTH = 4;

  // core clock, 250 MHz
  localparam int unsigned CORE_CLK_PERIOD_NS = 4;

  // values after reset
  localparam logic        SEL_N_RST  = 1'b1;
  localparam logic        SCLK_RST   = 1'b0;
  localparam logic [11:0] CODE_RST   = 12'h000;
  localparam logic [4:0]  CNT_RST    = 5'h00;

  // counter positions inside a frame
  localparam logic [4:0]  CNT_LAST_NULL = 5'(NULL_BITS - 1);
  localparam logic [4:0]  CNT_LAST_DATA = 5'(FRAME_BITS - 1);

  // frame sequencer states
  typedef enum logic [1:0] {
    DADC_ST_OFF  = 2'b00,
    DADC_ST_NULL = 2'b01,
    DADC_ST_DATA = 2'b10,
    DADC_ST_DONE = 2'b11
  } dadc_state_t;

  // one converted sample, two's complement
  typedef struct packed {
    logic signed [11:0] code;
  } dadc_smp_t;

  // synchronised pin levels
  typedef struct packed {
    logic sel_n;
    logic sclk;
  } dadc_link_t;

endpackage : dadc_pkg

// ==== src/dadc_readout.sv ====
`timescale 1ns/1ps
// How it works
// - select low means normal mode, select high means power-down
// - every falling select starts a conversion and a fresh frame
// - frame is four null bits then twelve data bits, msb first
// - while driven, result output changes only on falling serial clock edges
// - serial clock alone steps the conversion and the shifting
// - result is the signed input as twelve-bit two's complement

// small valid/ready fifo for front end samples
module dadc_fifo #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic             in_valid,
  output      logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output      logic             out_valid,
  input  wire logic             out_ready,
  output      logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction : ptr_inc

  // handshake and head word
  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_reg[rd_ptr_reg];

  // storage
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ptr_inc(wr_ptr_reg);
      end
      if (pop) begin
        rd_ptr_reg <= ptr_inc(rd_ptr_reg);
      end
      if (push && !pop) begin
        count_reg <= count_reg + (AW+1)'(1);
      end else if (pop && !push) begin
        count_reg <= count_reg - (AW+1)'(1);
      end
    end
  end
endmodule : dadc_fifo

// serial readout and successive approximation core
module dadc_readout #(
  parameter int unsigned FIFO_DEPTH = dadc_pkg::FIFO_DEPTH
) (
  input  wire logic                core_clk,
  input  wire logic                sys_rst,
  input  wire logic                conv_sel_n,
  input  wire logic                ser_clk,
  output      logic                ser_dout,
  output      logic                ser_dout_oe,
  output      logic                pwr_down,
  input  wire logic                smp_valid,
  output      logic                smp_ready,
  input  wire dadc_pkg::dadc_smp_t smp_data
);
  dadc_pkg::dadc_link_t  sync1_reg;
  dadc_pkg::dadc_link_t  sync2_reg;
  dadc_pkg::dadc_link_t  sync3_reg;
  dadc_pkg::dadc_state_t state_reg;
  logic [4:0]            cnt_reg;
  logic [11:0]           held_reg;
  logic [11:0]           sar_reg;
  logic                  dout_reg;
  logic                  oe_reg;
  logic                  pwr_reg;
  logic                  sel_fall;
  logic                  sclk_fall;
  logic                  in_frame;
  logic                  head_valid;
  dadc_pkg::dadc_smp_t   head_data;
  logic [11:0]           ubin;
  logic [3:0]            bit_idx;
  logic                  decide;
  logic                  out_bit;
  logic                  data_step;

  // trial value of a successive approximation step
  function automatic logic [11:0] sar_trial(input logic [11:0] acc,
                                            input logic [3:0]  idx);
    return acc | (12'h001 << idx);
  endfunction : sar_trial

  dadc_fifo #(
    .WIDTH ($bits(dadc_pkg::dadc_smp_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .in_valid  (smp_valid),
    .in_ready  (smp_ready),
    .in_data   (smp_data),
    .out_valid (head_valid),
    .out_ready (sel_fall),
    .out_data  (head_data)
  );

  // two-flop synchronisers plus one stage for edge detection
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_reg <= '{sel_n: dadc_pkg::SEL_N_RST, sclk: dadc_pkg::SCLK_RST};
      sync2_reg <= '{sel_n: dadc_pkg::SEL_N_RST, sclk: dadc_pkg::SCLK_RST};
      sync3_reg <= '{sel_n: dadc_pkg::SEL_N_RST, sclk: dadc_pkg::SCLK_RST};
    end else begin
      sync1_reg <= '{sel_n: conv_sel_n, sclk: ser_clk};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // edges of the synchronised pins
  assign sel_fall  = sync3_reg.sel_n && !sync2_reg.sel_n;
  assign sclk_fall = sync3_reg.sclk && !sync2_reg.sclk;
  assign in_frame  = (state_reg == dadc_pkg::DADC_ST_NULL) ||
                     (state_reg == dadc_pkg::DADC_ST_DATA);

  // one approximation step: offset-binary compare, msb flipped back
  assign ubin    = {~held_reg[11], held_reg[10:0]};
  assign bit_idx = 4'(dadc_pkg::FRAME_BITS - 2 - 32'(cnt_reg));
  assign decide  = (sar_trial(sar_reg, bit_idx) <= ubin);
  assign out_bit = (bit_idx == 4'hB) ? ~decide : decide;

  // falls that put data bits 11 down to 0 on the line, msb included
  assign data_step = sclk_fall && in_frame &&
                     (cnt_reg >= dadc_pkg::CNT_LAST_NULL) &&
                     (cnt_reg <  dadc_pkg::CNT_LAST_DATA);

  // power mode follows select level
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pwr_reg <= 1'b1;
    end else begin
      pwr_reg <= sync2_reg.sel_n;
    end
  end

  // frame sequencer and bit counter, stepped by serial clock
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= dadc_pkg::DADC_ST_OFF;
      cnt_reg   <= dadc_pkg::CNT_RST;
    end else if (sync2_reg.sel_n) begin
      state_reg <= dadc_pkg::DADC_ST_OFF;
      cnt_reg   <= dadc_pkg::CNT_RST;
    end else if (sel_fall) begin
      state_reg <= dadc_pkg::DADC_ST_NULL;
      cnt_reg   <= dadc_pkg::CNT_RST;
    end else if (sclk_fall && in_frame) begin
      cnt_reg <= cnt_reg + 5'h01;
      if (cnt_reg == dadc_pkg::CNT_LAST_NULL) begin
        state_reg <= dadc_pkg::DADC_ST_DATA;
      end else if (cnt_reg == dadc_pkg::CNT_LAST_DATA - 5'h01) begin
        state_reg <= dadc_pkg::DADC_ST_DONE;
      end
    end
  end

  // sample capture at conversion start, last sample kept if fifo is empty
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      held_reg <= dadc_pkg::CODE_RST;
    end else if (sel_fall && head_valid) begin
      held_reg <= head_data.code;
    end
  end

  // approximation accumulator, one decision per falling serial clock of the twelve data bits
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sar_reg <= dadc_pkg::CODE_RST;
    end else if (sel_fall) begin
      sar_reg <= dadc_pkg::CODE_RST;
    end else if (data_step) begin
      if (decide) begin
        sar_reg <= sar_trial(sar_reg, bit_idx);
      end
    end
  end

  // serial result bit and its enable
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dout_reg <= 1'b0;
      oe_reg   <= 1'b0;
    end else if (sync2_reg.sel_n) begin
      dout_reg <= 1'b0;
      oe_reg   <= 1'b0;
    end else if (sel_fall) begin
      dout_reg <= 1'b0;
      oe_reg   <= 1'b1;
    end else if (sclk_fall && state_reg != dadc_pkg::DADC_ST_OFF) begin
      if (data_step) begin
        dout_reg <= out_bit;
      end else begin
        dout_reg <= 1'b0;
      end
    end
  end

  assign ser_dout    = dout_reg;
  assign ser_dout_oe = oe_reg;
  assign pwr_down    = pwr_reg;

  // helper: word gathered from the line, checked against the sample
  logic [11:0] seen_reg;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      seen_reg <= dadc_pkg::CODE_RST;
    end else if (data_step) begin
      seen_reg <= {seen_reg[10:0], out_bit};
    end
  end

  a_pwr_follow: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    $rose(sync2_reg.sel_n) |=> pwr_down ##1 1'b1)
    else $error("power-down not entered after select rose");

  a_frame_start: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    sel_fall |=> (state_reg == dadc_pkg::DADC_ST_NULL) && cnt_reg == 5'h00
                 && ser_dout_oe && !ser_dout)
    else $error("select fall did not open a frame");

  a_null_lead: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    ((state_reg == dadc_pkg::DADC_ST_NULL) |-> !ser_dout)
    and ($rose(state_reg == dadc_pkg::DADC_ST_DATA) |-> cnt_reg == 5'h04))
    else $error("null bits wrong in frame head");

  a_msb_first: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (data_step && cnt_reg == dadc_pkg::CNT_LAST_NULL)
      |=> ser_dout == held_reg[11])
    else $error("first data bit is not the sample msb");

  a_frame_len: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    $rose(state_reg == dadc_pkg::DADC_ST_DONE)
      |-> cnt_reg == dadc_pkg::CNT_LAST_DATA)
    else $error("frame closed after wrong bit count");

  a_tail_zero: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (state_reg == dadc_pkg::DADC_ST_DONE && sclk_fall) |=> !ser_dout)
    else $error("result line not zero after the last data bit");

  a_dout_fall: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    ($changed(ser_dout) && ser_dout_oe && !$past(sel_fall))
      |-> $past(sclk_fall))
    else $error("result bit changed without a falling serial clock");

  a_step_sclk: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    ($changed(cnt_reg) && !$past(sel_fall) && !$past(sync2_reg.sel_n))
      |-> $past(sclk_fall) && cnt_reg == $past(cnt_reg) + 5'h01)
    else $error("conversion stepped without serial clock");

  a_twos_word: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    $rose(state_reg == dadc_pkg::DADC_ST_DONE) |-> seen_reg == held_reg)
    else $error("shifted word differs from two's complement sample");

  a_float_idle: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    sync2_reg.sel_n |=> !ser_dout_oe)
    else $error("result line driven while select high");

  c_full_frame: cover property (@(posedge core_clk) disable iff (sys_rst)
    $rose(state_reg == dadc_pkg::DADC_ST_DONE));
  c_fifo_full: cover property (@(posedge core_clk) disable iff (sys_rst)
    smp_valid && !smp_ready);
  c_abort_data: cover property (@(posedge core_clk) disable iff (sys_rst)
    state_reg == dadc_pkg::DADC_ST_DATA ##1 sync2_reg.sel_n);
  c_negative: cover property (@(posedge core_clk) disable iff (sys_rst)
    $rose(state_reg == dadc_pkg::DADC_ST_DONE) && held_reg[11]);
endmodule : dadc_readout

// ==== bench/dadc_host_model.sv ====
`timescale 1ns/1ps
// host side of the serial link: drives select and the serial clock
module dadc_host_model (
  output logic      sel_n,
  output logic      sclk,
  input  wire logic sdo_line
);
  // 125 ns serial clock period, inside the allowed band
  localparam real HALF_NS = 62.5;

  // select idles high, serial clock stands still low between frames
  initial begin
    sel_n = 1'b1;
    sclk  = 1'b0;
  end

  // one frame: select low, n clock pulses, bits taken on rising edges
  task frame(input int n, output logic [15:0] bits);
    bits  = 16'h0000;
    sel_n = 1'b0;
    #(HALF_NS);
    repeat (n) begin
      sclk = 1'b1;
      bits = {bits[14:0], sdo_line};
      #(HALF_NS);
      sclk = 1'b0;
      #(HALF_NS);
    end
    sel_n = 1'b1; // raised only after the requested count
    #(4 * HALF_NS); // gap keeps the frame rate near 430 kSPS
  endtask : frame
endmodule : dadc_host_model

// ==== bench/tb_diff_adc_serial_readout.sv ====
`timescale 1ns/1ps
module tb_diff_adc_serial_readout;
  logic                core_clk;
  logic                sys_rst;
  logic                conv_sel_n;
  logic                ser_clk;
  logic                ser_dout;
  logic                ser_dout_oe;
  logic                pwr_down;
  logic                smp_valid;
  logic                smp_ready;
  dadc_pkg::dadc_smp_t smp_data;
  wire                 ser_line;
  int                  err_total;
  int                  n_tests;
  int                  cyc;
  logic [15:0]         got;

  // result line floats when the device lets go
  assign ser_line = ser_dout_oe ? ser_dout : 1'bz;

  dadc_readout uut (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .conv_sel_n (conv_sel_n),
    .ser_clk    (ser_clk),
    .ser_dout   (ser_dout),
    .ser_dout_oe(ser_dout_oe),
    .pwr_down   (pwr_down),
    .smp_valid  (smp_valid),
    .smp_ready  (smp_ready),
    .smp_data   (smp_data)
  );

  dadc_host_model host (
    .sel_n   (conv_sel_n),
    .sclk    (ser_clk),
    .sdo_line(ser_line)
  );

  // 250 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // cuts a hang short
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      give_verdict();
    end
  end

  task chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // offer one sample and hold it until the fifo takes it
  task push(input logic [11:0] c);
    @(negedge core_clk);
    smp_valid     = 1'b1;
    smp_data.code = c;
    while (smp_ready !== 1'b1) @(negedge core_clk);
    @(negedge core_clk);
    smp_valid = 1'b0;
  endtask : push

  // released line and power-down between frames
  task check_idle();
    chk("line_released", 16'h0000, {15'h0000, ser_dout_oe});
    chk("power_down", 16'h0001, {15'h0000, pwr_down});
  endtask : check_idle

  // one frame, power-down looked at mid frame
  task test_basic();
    push(12'hA53);
    fork
      host.frame(16, got);
      begin
        #500;
        chk("normal_mode", 16'h0000, {15'h0000, pwr_down});
      end
    join
    chk("frame_negative", 16'h0A53, got);
    check_idle();
  endtask : test_basic

  // fill until refused, then drain by back-to-back frames
  task test_fifo();
    logic [11:0] codes [4];
    codes = '{12'h7FF, 12'h800, 12'h001, 12'hFFF};
    foreach (codes[i]) push(codes[i]);
    @(negedge core_clk);
    chk("fifo_full", 16'h0000, {15'h0000, smp_ready});
    foreach (codes[i]) begin
      host.frame(16, got);
      chk("frame_code", {4'h0, codes[i]}, got);
    end
    chk("fifo_room", 16'h0001, {15'h0000, smp_ready});
    host.frame(16, got);
    chk("frame_repeat", 16'h0FFF, got);
  endtask : test_fifo

  // select raised mid frame, next fall opens a fresh frame
  task test_abort();
    push(12'h5A5);
    host.frame(8, got);
    chk("frame_short", 16'h0005, got);
    check_idle();
    push(12'h3C3);
    host.frame(16, got);
    chk("frame_after_abort", 16'h03C3, got);
  endtask : test_abort

  task give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  // main sequence
  initial begin
    err_total = 0;
    n_tests   = 0;
    sys_rst   = 1'b1;
    smp_valid = 1'b0;
    smp_data  = '0;
    repeat (8) @(negedge core_clk);
    check_idle();
    chk("ready_after_reset", 16'h0001, {15'h0000, smp_ready});
    sys_rst = 1'b0;
    repeat (4) @(negedge core_clk);
    test_basic();
    test_fifo();
    test_abort();
    give_verdict();
  end
endmodule : tb_diff_adc_serial_readout
